// *** hdl/mcic_pkg.sv ***
/*
  constants shared by the memory card interface controller: register
  indices, bit fields, reset values and timing counts.
  assumes a 20 mhz system clock.
*/
package mcic_pkg;
  localparam int HAW = 4;   // host register index width
  localparam int DW  = 8;   // host and card data width
  localparam int CAW = 26;  // card address counter width
  // register indices
  localparam logic [3:0] REG_DATA = 4'h0;  // card data port
  localparam logic [3:0] REG_ADR0 = 4'h1;
  localparam logic [3:0] REG_ADR1 = 4'h2;
  localparam logic [3:0] REG_ADR2 = 4'h3;
  localparam logic [3:0] REG_ADR3 = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h5;
  localparam logic [3:0] REG_STAT = 4'h6;
  localparam logic [3:0] REG_CFG  = 4'h7;
  // control bits, all active low on their pins
  localparam int CB_PWR  = 0;
  localparam int CB_BATT = 1;
  localparam int CB_BUSY = 2;
  localparam int CB_REGN = 3;
  localparam logic [7:0] CTRL_RST = 8'h0f;
  // status bits
  localparam int SB_IRQ  = 0;
  localparam int SB_INS  = 1;
  // wait states
  localparam logic [1:0] CARD_WAIT = 2'h2;
  localparam logic [1:0] REG_WAIT  = 2'h0;
  // card strobe width
  localparam int CLK_NS  = 50;
  localparam int STB_NS  = 150;
  localparam int STB_CYC = (STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYW     = 29;  // width of synchronised pin vector
endpackage : mcic_pkg

// *** hdl/mcic_ctrl.sv ***
/*
  memory card interface controller: host register port with wait
  states, card access engine with address counter, two-entry write
  buffer, card detect interrupt and serial configuration load.
  assumes host pins are asynchronous and resolved by external pull-ups.
*/
// Contract
// RQ1: read places indexed register on data byte
// RQ2: write latches data byte at access end
// RQ3: zero-wait access acknowledged next clock edge
// RQ4: acknowledge driven only when we are target
// RQ5: wait states counted before acknowledge
// RQ6: card data accesses get two waits
// RQ7: config enable low while shifting, then released
// RQ8: card address from 26-bit counter
// RQ9: eight-bit card data with card strobes
// RQ10: register select picks attribute or common
// RQ11: address counter increments after each cycle
// RQ12: card read enable then read strobe
// RQ13: card write enable then write strobe
// RQ14: insert and remove both raise interrupt
// RQ15: inserted when both detects low
// RQ16: host-controlled active-low card power
// RQ17: write-protect level sampled, high protects
// RQ18: battery led driven low on host request
// RQ19: busy led driven low on host request
// RQ20: status readable, controls host writable
// RQ21: acknowledge released when select deasserts
`timescale 1ns/100ps
`default_nettype none
module mcic_ctrl #(
  parameter int DEPTH    = 2,
  parameter int CFG_BITS = 8
) (
  input  wire logic                     CLK_I,
  input  wire logic                     RST_B_I,
  input  wire logic [mcic_pkg::HAW-1:0] HOST_ADDR_I,
  input  wire logic                     CTRL_SELECT_N_I,
  input  wire logic                     HOST_READ_STROBE_N_I,
  input  wire logic                     HOST_WRITE_STROBE_N_I,
  input  wire logic [mcic_pkg::DW-1:0]  HOST_DATA_I,
  output logic      [mcic_pkg::DW-1:0]  HOST_DATA_O,
  output logic                          HOST_DATA_OE_O,
  output logic                          TRANSFER_ACK_N_O,
  output logic                          TRANSFER_ACK_OE_O,
  output logic                          CARD_IRQ_N_O,
  output logic                          CFG_CE_N_O,
  output logic                          CFG_CE_OE_O,
  output logic                          CFG_CLK_O,
  input  wire logic                     CFG_DATA_I,
  output logic      [mcic_pkg::CAW-1:0] CARD_ADDR_O,
  input  wire logic [mcic_pkg::DW-1:0]  CARD_DATA_I,
  output logic      [mcic_pkg::DW-1:0]  CARD_DATA_O,
  output logic                          CARD_DATA_OE_O,
  output logic                          CARD_REG_N_O,
  output logic                          CARD_ENABLE_N_O,
  output logic                          CARD_READ_STROBE_N_O,
  output logic                          CARD_WRITE_STROBE_N_O,
  input  wire logic                     CARD_DET1_I,
  input  wire logic                     CARD_DET2_I,
  input  wire logic                     CARD_WP_I,
  input  wire logic                     CARD_BVD1_I,
  input  wire logic                     CARD_BVD2_I,
  output logic                          CARD_PWR_N_O,
  output logic                          BATT_LED_N_O,
  output logic                          BUSY_LED_N_O
);
  import mcic_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef enum logic [2:0] {H_IDLE = 3'h1, H_WAIT = 3'h2, H_ACK = 3'h4} mcic_hst_t;
  typedef enum logic [3:0] {C_IDLE = 4'h1, C_EN = 4'h2, C_STB = 4'h4, C_END = 4'h8} mcic_cst_t;
  typedef enum logic [1:0] {CF_LOAD = 2'h1, CF_DONE = 2'h2} mcic_cfs_t;

  mcic_hst_t        hst_r;
  mcic_cst_t        cst_r;
  mcic_cfs_t        cfs_r;
  logic [SYW-1:0]   s1_r;
  logic [SYW-1:0]   s2_r;
  logic             sel_s;
  logic             rd_s;
  logic             wr_s;
  logic [HAW-1:0]   adr_s;
  logic [DW-1:0]    hd_s;
  logic [DW-1:0]    cd_s;
  logic [4:0]       pin_s;
  logic             cfgd_s;
  logic [HAW-1:0]   adr_r;
  logic             rdw_r;
  logic             card_r;
  logic [1:0]       wcnt_r;
  logic [DW-1:0]    hdo_r;
  logic [DW-1:0]    whd_r;
  logic [DW-1:0]    rmux;
  logic             go;
  logic             acc_end;
  logic             wr_commit;
  logic [DW-1:0]    ctrl_r;
  logic [CAW-1:0]   caddr_r;
  logic             irq_r;
  logic             ins_r;
  logic             ins_now;
  logic [DW-1:0]    mem_r [DEPTH];
  logic [PW-1:0]    wp_r;
  logic [PW-1:0]    rp_r;
  logic [CW-1:0]    cnt_r;
  logic             in_rdy;
  logic             out_vld;
  logic             push;
  logic             pop;
  logic             rd_req;
  logic             rd_done_r;
  logic             crd_r;
  logic [DW-1:0]    cwd_r;
  logic [DW-1:0]    crdat_r;
  logic [7:0]       scnt_r;
  logic             cclk_r;
  logic [7:0]       ccnt_r;
  logic [DW-1:0]    cfg_r;
  logic             addr_wr;

  default clocking dc @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; only s2_r is read by logic
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      s1_r <= '1;
      s2_r <= '1;
    end
    else
    begin
      s1_r <= {CTRL_SELECT_N_I, HOST_READ_STROBE_N_I, HOST_WRITE_STROBE_N_I,
               HOST_ADDR_I, HOST_DATA_I, CARD_DATA_I, CARD_DET1_I,
               CARD_DET2_I, CARD_WP_I, CARD_BVD1_I, CARD_BVD2_I, CFG_DATA_I};
      s2_r <= s1_r;
    end
  end

  assign {sel_s, rd_s, wr_s, adr_s, hd_s, cd_s, pin_s, cfgd_s} = s2_r;
  assign ins_now = !pin_s[4] && !pin_s[3];  // RQ15

  ////////////////////////////////////////////////////////////////////////
  // host access sequencer; card accesses also wait on the engine or buffer
  assign go = !card_r || (rdw_r ? rd_done_r : in_rdy);  // RQ6
  assign acc_end = (hst_r == H_ACK) && sel_s;
  assign wr_commit = acc_end && !rdw_r;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      hst_r  <= H_IDLE;
      adr_r  <= '0;
      rdw_r  <= 1'b0;
      card_r <= 1'b0;
      wcnt_r <= '0;
      hdo_r  <= '0;
      whd_r  <= '0;
    end
    else
    begin
      case (hst_r)
        H_IDLE:
          if (!sel_s && (!rd_s || !wr_s))
          begin
            hst_r  <= H_WAIT;
            adr_r  <= adr_s;
            rdw_r  <= !rd_s;
            card_r <= (adr_s == REG_DATA);
            wcnt_r <= (adr_s == REG_DATA) ? CARD_WAIT : REG_WAIT;  // RQ6
          end
        H_WAIT:
          if (wcnt_r != 2'h0)
            wcnt_r <= wcnt_r - 2'h1;  // RQ5
          else if (go)
          begin
            hst_r <= H_ACK;  // RQ3
            hdo_r <= rmux;   // RQ1
            whd_r <= hd_s;
          end
        H_ACK:
          if (sel_s)
            hst_r <= H_IDLE;  // RQ21
        default:
          hst_r <= H_IDLE;
      endcase
    end
  end

  // read data source for every index; unmapped indices read zero
  always_comb
  begin
    case (adr_r)
      REG_DATA: rmux = crdat_r;
      REG_ADR0: rmux = caddr_r[7:0];
      REG_ADR1: rmux = caddr_r[15:8];
      REG_ADR2: rmux = caddr_r[23:16];
      REG_ADR3: rmux = {6'h00, caddr_r[25:24]};
      REG_CTRL: rmux = ctrl_r;
      REG_STAT: rmux = {1'b0, pin_s, ins_now, irq_r};  // RQ17 RQ20
      REG_CFG:  rmux = cfg_r;
      default:  rmux = 8'h00;
    endcase
  end

  assign HOST_DATA_O       = hdo_r;
  assign HOST_DATA_OE_O    = (hst_r == H_ACK) && rdw_r;  // RQ1
  assign TRANSFER_ACK_N_O  = 1'b0;
  assign TRANSFER_ACK_OE_O = (hst_r == H_ACK);  // RQ4

  zero_wait_a: assert property ((hst_r == H_WAIT) && !card_r |=> TRANSFER_ACK_OE_O)  // RQ3
    else $error("register access not acknowledged in one cycle");
  ack_target_a: assert property (TRANSFER_ACK_OE_O |-> (hst_r == H_ACK) && !$past(sel_s))  // RQ4
    else $error("acknowledge driven while not selected");
  card_wait_a: assert property ($rose(hst_r == H_WAIT) && card_r |-> !TRANSFER_ACK_OE_O [*3])  // RQ6
    else $error("card access acknowledged before two wait states");
  ack_release_a: assert property (acc_end |=> !TRANSFER_ACK_OE_O)  // RQ21
    else $error("acknowledge held after select released");

  ////////////////////////////////////////////////////////////////////////
  // control register and interrupt flag; a new event beats the clear
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      ctrl_r <= CTRL_RST;
      irq_r  <= 1'b0;
      ins_r  <= 1'b0;
    end
    else
    begin
      ins_r <= ins_now;
      if (wr_commit && (adr_r == REG_CTRL))
        ctrl_r <= whd_r;  // RQ2 RQ16 RQ18 RQ19
      if (ins_now != ins_r)
        irq_r <= 1'b1;  // RQ14
      else if (wr_commit && (adr_r == REG_STAT) && whd_r[SB_IRQ])
        irq_r <= 1'b0;
    end
  end

  assign CARD_IRQ_N_O = !irq_r;
  assign CARD_PWR_N_O = ctrl_r[CB_PWR];   // RQ16
  assign BATT_LED_N_O = ctrl_r[CB_BATT];  // RQ18
  assign BUSY_LED_N_O = ctrl_r[CB_BUSY];  // RQ19
  assign CARD_REG_N_O = ctrl_r[CB_REGN];  // RQ10

  irq_event_a: assert property ((ins_now != ins_r) |=> !CARD_IRQ_N_O)  // RQ14
    else $error("card detect change did not raise interrupt");
  ctrl_write_a: assert property (wr_commit && (adr_r == REG_CTRL)
                                 |=> CARD_PWR_N_O == $past(whd_r[CB_PWR]))  // RQ16
    else $error("power control not taken from host write");

  ////////////////////////////////////////////////////////////////////////
  // card address counter; a host write in the same cycle wins
  assign addr_wr = wr_commit && (adr_r >= REG_ADR0) && (adr_r <= REG_ADR3);

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
      caddr_r <= '0;
    else if (addr_wr)
      case (adr_r)
        REG_ADR0: caddr_r[7:0]   <= whd_r;
        REG_ADR1: caddr_r[15:8]  <= whd_r;
        REG_ADR2: caddr_r[23:16] <= whd_r;
        default:  caddr_r[25:24] <= whd_r[1:0];
      endcase
    else if (cst_r == C_END)
      caddr_r <= caddr_r + 26'h1;  // RQ11
  end

  assign CARD_ADDR_O = caddr_r;  // RQ8

  addr_inc_a: assert property ((cst_r == C_END) && !addr_wr
                               |=> CARD_ADDR_O == $past(CARD_ADDR_O) + 26'h1)  // RQ11
    else $error("address counter did not advance after card cycle");

  ////////////////////////////////////////////////////////////////////////
  // two-entry write buffer; a full buffer holds off the acknowledge
  assign in_rdy  = (cnt_r < CW'(DEPTH));
  assign out_vld = (cnt_r != '0);
  assign push    = wr_commit && card_r;
  assign rd_req  = (hst_r == H_WAIT) && card_r && rdw_r && !rd_done_r;
  assign pop     = (cst_r == C_IDLE) && out_vld && !ctrl_r[CB_PWR];

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_r[wp_r] <= whd_r;
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
      end
      if (pop)
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // card cycle engine; buffered writes drain before a read is served
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      cst_r     <= C_IDLE;
      crd_r     <= 1'b0;
      cwd_r     <= '0;
      crdat_r   <= '0;
      scnt_r    <= '0;
      rd_done_r <= 1'b0;
    end
    else
    begin
      if (acc_end)
        rd_done_r <= 1'b0;
      case (cst_r)
        C_IDLE:
          if (pop)
          begin
            cst_r <= C_EN;
            crd_r <= 1'b0;
            cwd_r <= mem_r[rp_r];  // RQ13
          end
          else if (rd_req && !out_vld)
          begin
            cst_r <= C_EN;
            crd_r <= 1'b1;
          end
        C_EN:
        begin
          cst_r  <= C_STB;  // RQ12 RQ13
          scnt_r <= '0;
        end
        C_STB:
          if (scnt_r == 8'(STB_CYC - 1))
          begin
            cst_r <= C_END;
            if (crd_r)
            begin
              crdat_r   <= cd_s;  // RQ9 RQ12
              rd_done_r <= 1'b1;
            end
          end
          else
            scnt_r <= scnt_r + 8'h1;
        C_END:
          cst_r <= C_IDLE;
        default:
          cst_r <= C_IDLE;
      endcase
    end
  end

  assign CARD_ENABLE_N_O       = (cst_r == C_IDLE);  // RQ9
  assign CARD_READ_STROBE_N_O  = !((cst_r == C_STB) && crd_r);
  assign CARD_WRITE_STROBE_N_O = !((cst_r == C_STB) && !crd_r);
  assign CARD_DATA_O           = cwd_r;
  assign CARD_DATA_OE_O        = (cst_r != C_IDLE) && !crd_r;  // RQ13

  sequence enable_lead_s;
    !CARD_ENABLE_N_O && CARD_READ_STROBE_N_O && CARD_WRITE_STROBE_N_O;
  endsequence
  sequence strobe_on_s;
    !CARD_ENABLE_N_O && (!CARD_READ_STROBE_N_O || !CARD_WRITE_STROBE_N_O);
  endsequence
  enable_first_a: assert property ($fell(CARD_ENABLE_N_O) |-> enable_lead_s ##1 strobe_on_s)  // RQ12
    else $error("card strobe not preceded by enable");
  write_drive_a: assert property (!CARD_WRITE_STROBE_N_O |-> CARD_DATA_OE_O)  // RQ13
    else $error("card write strobe without data drive");

  ////////////////////////////////////////////////////////////////////////
  // serial configuration load after reset; enable released when done
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      cfs_r  <= CF_LOAD;
      cclk_r <= 1'b0;
      ccnt_r <= '0;
      cfg_r  <= '0;
    end
    else if (cfs_r == CF_LOAD)
    begin
      cclk_r <= !cclk_r;  // RQ7
      if (cclk_r)
      begin
        cfg_r  <= {cfg_r[DW-2:0], cfgd_s};
        ccnt_r <= ccnt_r + 8'h1;
        if (ccnt_r == 8'(CFG_BITS - 1))
          cfs_r <= CF_DONE;
      end
    end
  end

  assign CFG_CLK_O   = cclk_r;
  assign CFG_CE_N_O  = 1'b0;
  assign CFG_CE_OE_O = (cfs_r == CF_LOAD);  // RQ7

  cfg_release_a: assert property ((cfs_r == CF_DONE) |-> !CFG_CE_OE_O && !CFG_CLK_O)  // RQ7
    else $error("configuration enable not released after load");
endmodule : mcic_ctrl
`default_nettype wire

// *** test/mcic_card_model.sv ***
/*
  behavioural memory card and serial configuration memory for the
  controller bench.
  assumes card strobes and enable are active low and decoded from state.
*/
`timescale 1ns/100ps
`default_nettype none
module mcic_card_model (
  input  wire logic        clk_i,
  input  wire logic [25:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        ce_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        oe_i,
  input  wire logic        cfg_oe_i,
  input  wire logic        cfg_clk_i,
  output logic      [7:0]  rdata_o,
  output logic             cfg_data_o
);
  logic [7:0] mem [0:63];
  logic [7:0] last_r = 8'h00;
  logic [7:0] cfg_sh = 8'ha5;
  ////////////////////////////////////////////////////////////////////////
  // store a byte while enable and write strobe are both low; an undriven bus stores garbage
  always @(posedge clk_i)
  begin
    if (!ce_n_i && !wr_n_i)
      mem[addr_i[5:0]] <= oe_i ? wdata_i : ~wdata_i;
  end
  // undriven bus shows the inverse of the last byte, never a stale match
  always @(posedge clk_i)
  begin
    if (!ce_n_i && !rd_n_i)
      last_r <= mem[addr_i[5:0]];
  end
  assign rdata_o = (!ce_n_i && !rd_n_i) ? mem[addr_i[5:0]] : ~last_r;
  ////////////////////////////////////////////////////////////////////////
  // config memory shifts a bit on each falling clock while enabled
  always @(negedge cfg_clk_i)
  begin
    if (cfg_oe_i)
      cfg_sh <= {cfg_sh[6:0], cfg_sh[7]};
  end
  assign cfg_data_o = cfg_oe_i ? cfg_sh[7] : ~cfg_sh[7];
endmodule : mcic_card_model
`default_nettype wire

// *** test/memory_card_interface_controller_bench.sv ***
/*
  self-checking bench for the card interface controller with a card model.
  assumes host pins pass the design's synchronisers, so answers come late.
*/
`timescale 1ns/100ps
`default_nettype none
module memory_card_interface_controller_bench;
  import mcic_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, sel_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  logic [3:0]  h_addr = 4'h0;
  logic [7:0]  h_wdata = 8'h00, h_rdata, c_rdata, c_wdata, q;
  logic [25:0] c_addr, a;
  logic ack_oe, irq_n, cfg_oe, cfg_clk, cfg_d, c_oe, reg_n, ce_n, crd_n, cwr_n;
  logic h_oe, ack_n, cfg_ce_n;
  logic pwr_n, batt_n, busy_n, det1 = 1'b1, det2 = 1'b1, wp = 1'b0, bvd1 = 1'b1, bvd2 = 1'b1;
  int   err_count = 0, comparisons = 0, rcyc, ccyc, n;
  logic [7:0] bytes [0:5];
  always #25 clk = ~clk;
  mcic_ctrl #(.DEPTH(2), .CFG_BITS(4)) dut_u (
    .CLK_I(clk), .RST_B_I(rst_b), .HOST_ADDR_I(h_addr), .CTRL_SELECT_N_I(sel_n),
    .HOST_READ_STROBE_N_I(rd_n), .HOST_WRITE_STROBE_N_I(wr_n), .HOST_DATA_I(h_wdata),
    .HOST_DATA_O(h_rdata), .HOST_DATA_OE_O(h_oe), .TRANSFER_ACK_N_O(ack_n),
    .TRANSFER_ACK_OE_O(ack_oe), .CARD_IRQ_N_O(irq_n), .CFG_CE_N_O(cfg_ce_n),
    .CFG_CE_OE_O(cfg_oe), .CFG_CLK_O(cfg_clk),
    .CFG_DATA_I(cfg_d), .CARD_ADDR_O(c_addr), .CARD_DATA_I(c_rdata), .CARD_DATA_O(c_wdata),
    .CARD_DATA_OE_O(c_oe), .CARD_REG_N_O(reg_n), .CARD_ENABLE_N_O(ce_n),
    .CARD_READ_STROBE_N_O(crd_n), .CARD_WRITE_STROBE_N_O(cwr_n), .CARD_DET1_I(det1),
    .CARD_DET2_I(det2), .CARD_WP_I(wp), .CARD_BVD1_I(bvd1), .CARD_BVD2_I(bvd2),
    .CARD_PWR_N_O(pwr_n), .BATT_LED_N_O(batt_n), .BUSY_LED_N_O(busy_n));
  mcic_card_model card_u (
    .clk_i(clk), .addr_i(c_addr), .wdata_i(c_wdata), .ce_n_i(ce_n), .rd_n_i(crd_n),
    .wr_n_i(cwr_n), .oe_i(c_oe), .cfg_oe_i(cfg_oe), .cfg_clk_i(cfg_clk), .rdata_o(c_rdata),
    .cfg_data_o(cfg_d));
  ////////////////////////////////////////////////////////////////////////
  // verdict and comparison helpers
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one host access: hold select and strobe until ack is seen, then release
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [7:0] d, output int cyc);
    n = 0;
    h_addr <= ad;
    h_wdata <= d;
    sel_n <= 1'b0;
    rd_n <= wr;
    wr_n <= !wr;
    do begin @(posedge clk); n++; end while (ack_oe !== 1'b1 && n < 200);
    q = h_rdata;
    cyc = n;
    check(n < 200, 1);
    check({h_oe, ack_n}, {!wr, 1'b0});
    sel_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (ack_oe !== 1'b0 && n < 20);
    repeat (3) @(posedge clk);
    check({ack_oe, h_oe}, 2'b00);
  endtask : bus
  task automatic set_addr(input logic [25:0] v);
    bus(1, REG_ADR0, v[7:0], n);
    bus(1, REG_ADR1, v[15:8], n);
    bus(1, REG_ADR2, v[23:16], n);
    bus(1, REG_ADR3, {6'h00, v[25:24]}, n);
  endtask : set_addr
  function automatic logic [7:0] stat_exp(input logic ins);
    return {1'b0, ~ins, ~ins, wp, bvd1, bvd2, ins, 1'b0};
  endfunction : stat_exp
  ////////////////////////////////////////////////////////////////////////
  // watchdog counts a mismatch if the tests overrun
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end
  // main sequence
  initial
  begin
    void'($urandom(649));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // buffer fills with power off: two writes taken, the third held back
    bus(1, REG_DATA, 8'h11, n);
    bus(1, REG_DATA, 8'h22, n);
    sel_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (30) @(posedge clk);
    check(ack_oe, 0);
    rst_b <= 1'b0;
    sel_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check({pwr_n, batt_n, busy_n, reg_n, c_addr}, {4'hf, 26'h0});
    $display("buffer and reset test done");
    check({cfg_oe, cfg_ce_n}, 2'b10);
    // config load: enable held, exactly the set number of clocks
    n = 0;
    rcyc = 0;
    while (cfg_oe === 1'b1 && rcyc < 100)
    begin
      @(posedge clk);
      rcyc++;
      if (cfg_clk === 1'b1) n++;
    end
    repeat (4) @(posedge clk);
    check({cfg_oe, cfg_clk, 30'(n)}, {2'b00, 30'h4});
    $display("config test done");
    // control bits drive the pins; attribute select, readback
    bus(1, REG_CTRL, 8'h00, rcyc);
    check({pwr_n, batt_n, busy_n, reg_n}, 4'h0);
    bus(0, REG_CTRL, 8'h5a, n);
    check(q, 8'h00);
    bus(1, REG_CTRL, 8'h08, n);
    check(reg_n, 1);
    check(rcyc <= 5, 1);
    $display("control test done");
    // card writes at a random address, counter advances per byte
    a = 26'($urandom);
    set_addr(a);
    check(c_addr, a);
    for (int i = 0; i < 6; i++)
    begin
      bytes[i] = 8'($urandom);
      bus(1, REG_DATA, bytes[i], ccyc);
      if (i == 0) check(ccyc >= rcyc + 2, 1);
    end
    repeat (40) @(posedge clk);
    check(c_addr, a + 26'd6);
    // address bytes read back the live counter; unmapped index reads zero
    bus(0, REG_ADR0, 8'h00, n);
    check(q, 8'(a + 26'h6));
    bus(0, REG_ADR3, 8'h00, n);
    check(q, {6'h00, 2'((a + 26'h6) >> 24)});
    bus(0, 4'hf, 8'h00, n);
    check(q, 8'h00);
    set_addr(a);
    for (int i = 0; i < 6; i++)
    begin
      bus(0, REG_DATA, 8'($urandom), n);
      check(q, bytes[i]);
    end
    check(c_addr, a + 26'd6);
    $display("card data test done");
    // insertion needs both detects low; removal also interrupts
    wp <= 1'($urandom);
    bvd1 <= 1'($urandom);
    det1 <= 1'b0;
    repeat (12) @(posedge clk);
    check(irq_n, 1);
    det2 <= 1'b0;
    repeat (12) @(posedge clk);
    check(irq_n, 0);
    bus(1, REG_STAT, 8'h01, n);
    check(irq_n, 1);
    bus(0, REG_STAT, 8'h00, n);
    check(q, stat_exp(1));
    det1 <= 1'b1;
    det2 <= 1'b1;
    repeat (12) @(posedge clk);
    check(irq_n, 0);
    $display("card detect test done");
    stop_test();
  end
endmodule : memory_card_interface_controller_bench
`default_nettype wire
